// ===== inc/liuhw_map.svh
`ifndef LIUHW_MAP_SVH
`define LIUHW_MAP_SVH

`define LIUHW_NUM_CH          8
`define LIUHW_DMO_LIMIT       128
`define LIUHW_LOS_ZEROS_E1    32
`define LIUHW_LOS_ZEROS_T1    175
`define LIUHW_RESET_MIN_NS    10000
`define LIUHW_CLK_NS          10
`define LIUHW_RESET_CYCLES    ((`LIUHW_RESET_MIN_NS + `LIUHW_CLK_NS - 1) / `LIUHW_CLK_NS)

`define LIUHW_OFF_CTRL        12'h000
`define LIUHW_OFF_LOOP        12'h004
`define LIUHW_OFF_STATUS      12'h008
`define LIUHW_OFF_MASK        12'h00C
`define LIUHW_OFF_RAW         12'h010
`define LIUHW_OFF_TERM        12'h014
`define LIUHW_OFF_CFG         12'h018

`define LIUHW_CTRL_HOSTMODE   0
`define LIUHW_CTRL_AAO        1
`define LIUHW_CTRL_RAIL       2
`define LIUHW_CTRL_GAUGE      3
`define LIUHW_CTRL_RATIO      4
`define LIUHW_CTRL_TXT        5
`define LIUHW_CTRL_RXT        6
`define LIUHW_CTRL_E1         7
`define LIUHW_CTRL_TER_LO     8
`define LIUHW_CTRL_RXT_PIN    10

`define LIUHW_RST_CTRL        32'h0000_0000

`endif

// ===== inc/liuhw_pkg.sv
package liuhw_pkg;
	typedef enum logic [1:0] {
		liuhw_lb_normal,
		liuhw_lb_local,
		liuhw_lb_remote,
		liuhw_lb_digital
	} liuhw_loop_t;

	typedef enum logic [1:0] {
		liuhw_ohm_100,
		liuhw_ohm_110,
		liuhw_ohm_75,
		liuhw_ohm_120
	} liuhw_ohm_t;

	typedef enum {
		liuhw_ph_addr,
		liuhw_ph_data
	} liuhw_phase_t;
endpackage

// ===== core/liuhw_los_det.sv
`timescale 1ns/1ps
`include "liuhw_map.svh"

module liuhw_los_det
	import liuhw_pkg::*;
#(
	parameter int E1_ZEROS = `LIUHW_LOS_ZEROS_E1,
	parameter int T1_ZEROS = `LIUHW_LOS_ZEROS_T1
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic bit_en,
	input  wire logic rx_bit,
	input  wire logic analog_loss,
	input  wire logic e1_mode,
	output logic      los
);
	logic [7:0] zeros;
	logic [7:0] next_zeros;
	logic       next_los;
	logic [7:0] limit;

	always_comb begin
		limit      = e1_mode ? 8'(E1_ZEROS) : 8'(T1_ZEROS);
		next_zeros = zeros;
		next_los   = los;
		if (!analog_loss) begin
			next_zeros = 8'h00;
			next_los   = 1'b0;
		end else if (bit_en) begin
			if (rx_bit) begin
				next_zeros = 8'h00;
			end else if (zeros < limit) begin
				next_zeros = zeros + 8'h01;
			end
			// Declared only after the full run of zeros
			if (!rx_bit && zeros + 8'h01 >= limit) begin
				next_los = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zeros <= 8'h00;
			los   <= 1'b0;
		end else begin
			zeros <= next_zeros;
			los   <= next_los;
		end
	end
endmodule

// ===== core/liuhw_drv_mon.sv
`timescale 1ns/1ps
`include "liuhw_map.svh"

module liuhw_drv_mon
	import liuhw_pkg::*;
#(
	parameter int LIMIT = `LIUHW_DMO_LIMIT
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic tx_clk_en,
	input  wire logic tx_pulse,
	input  wire logic short_det,
	output logic      fault
);
	logic [7:0] idle;
	logic [7:0] next_idle;
	logic       next_fault;

	always_comb begin
		next_idle  = idle;
		if (tx_pulse) begin
			next_idle = 8'h00;
		end else if (tx_clk_en && idle <= 8'(LIMIT)) begin
			next_idle = idle + 8'h01;
		end
		// Flag tracks the live condition, clears once pulses return
		next_fault = short_det || (idle > 8'(LIMIT));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle  <= 8'h00;
			fault <= 1'b0;
		end else begin
			idle  <= next_idle;
			fault <= next_fault;
		end
	end
endmodule

// ===== core/liuhw_ctrl.sv
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "liuhw_map.svh"

module liuhw_ctrl
	import liuhw_pkg::*;
#(
	parameter int NUM_CH       = `LIUHW_NUM_CH,
	parameter int RESET_CYCLES = `LIUHW_RESET_CYCLES
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [11:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              chip_reset_n,
	input  wire logic              auto_all_ones_on_loss,
	input  wire logic              rail_format_select,
	input  wire logic              cable_gauge_select,
	input  wire logic              tx_transformer_ratio_select,
	input  wire logic              tx_termination_select,
	input  wire logic              rx_termination_select,
	input  wire logic [1:0]        termination_impedance_select,
	input  wire logic [NUM_CH-1:0] loopback_sel_hi,
	input  wire logic [NUM_CH-1:0] loopback_sel_lo,
	input  wire logic [NUM_CH-1:0] channel_tx_clock,
	input  wire logic [NUM_CH-1:0] tx_pulse_seen,
	input  wire logic [NUM_CH-1:0] tx_short_detect,
	input  wire logic [NUM_CH-1:0] rx_bit_en,
	input  wire logic [NUM_CH-1:0] rx_bit,
	input  wire logic [NUM_CH-1:0] rx_analog_loss,
	input  wire logic [NUM_CH-1:0] tx_data,
	output logic      [NUM_CH-1:0] driver_fault_flag,
	output logic      [NUM_CH-1:0] receive_loss_of_signal,
	output logic      [NUM_CH-1:0] tx_line_data,
	output logic      [NUM_CH-1:0] tx_send_all_ones,
	output logic      [NUM_CH-1:0] lb_local,
	output logic      [NUM_CH-1:0] lb_remote,
	output logic      [NUM_CH-1:0] lb_digital,
	output logic                   single_rail,
	output logic                   coder_bypass,
	output logic                   gauge_26,
	output logic                   ratio_1_to_2,
	output logic                   tx_term_internal,
	output logic      [NUM_CH-1:0] rx_term_internal,
	output logic      [1:0]        term_impedance,
	output logic                   term_impedance_valid,
	output logic                   device_in_reset,
	output logic                   irq,
	output logic                   int_n_out,
	output logic                   int_n_oe
);
	logic [31:0]       ctrl;
	logic [31:0]       next_ctrl;
	logic [2*NUM_CH-1:0] loopreg;
	logic [2*NUM_CH-1:0] next_loopreg;
	logic [2*NUM_CH-1:0] status;
	logic [2*NUM_CH-1:0] next_status;
	logic [2*NUM_CH-1:0] mask;
	logic [2*NUM_CH-1:0] next_mask;
	logic [NUM_CH-1:0] rxterm;
	logic [NUM_CH-1:0] next_rxterm;
	logic [11:0]       a_addr;
	logic              a_wr;
	logic              a_rd;
	logic [11:0]       next_a_addr;
	logic              next_a_wr;
	logic              next_a_rd;
	logic [31:0]       next_hrdata;
	logic [13:0]       rst_cnt;
	logic [13:0]       next_rst_cnt;
	logic              next_in_reset;
	logic [NUM_CH-1:0] tclk_q;
	logic [2*NUM_CH-1:0] events;
	logic [2*NUM_CH-1:0] ev_prev;
	logic              host_mode;
	logic              e1_mode;
	logic              take;

	function automatic logic [1:0] loop_sel(input logic [2*NUM_CH-1:0] bits, input int ch);
		loop_sel = bits[2*ch +: 2];
	endfunction

	assign host_mode = ctrl[`LIUHW_CTRL_HOSTMODE];
	assign e1_mode   = ctrl[`LIUHW_CTRL_E1];

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			logic [1:0] mode;
			// Transmit clock rising edge seen on the system clock
			liuhw_drv_mon u_mon (
				.hclk      (hclk),
				.hresetn   (hresetn),
				.tx_clk_en (channel_tx_clock[g] & ~tclk_q[g]),
				.tx_pulse  (tx_pulse_seen[g]),
				.short_det (tx_short_detect[g]),
				.fault     (driver_fault_flag[g])
			);
			liuhw_los_det u_los (
				.hclk        (hclk),
				.hresetn     (hresetn),
				.bit_en      (rx_bit_en[g]),
				.rx_bit      (rx_bit[g]),
				.analog_loss (rx_analog_loss[g]),
				.e1_mode     (e1_mode),
				.los         (receive_loss_of_signal[g])
			);
			assign mode = host_mode ? loop_sel(loopreg, g) : {loopback_sel_hi[g], loopback_sel_lo[g]};
			assign lb_local[g]   = (mode == liuhw_lb_local);
			assign lb_remote[g]  = (mode == liuhw_lb_remote);
			assign lb_digital[g] = (mode == liuhw_lb_digital);
			assign tx_send_all_ones[g] = (host_mode ? ctrl[`LIUHW_CTRL_AAO] : auto_all_ones_on_loss)
				& receive_loss_of_signal[g];
			assign tx_line_data[g] = tx_send_all_ones[g] | tx_data[g];
			// Pin path wins when host hands receive termination to hardware
			assign rx_term_internal[g] = (host_mode && !ctrl[`LIUHW_CTRL_RXT_PIN]) ? rxterm[g]
				: rx_termination_select;
		end
	endgenerate

	assign events = {receive_loss_of_signal, driver_fault_flag};

	always_comb begin
		single_rail      = host_mode ? ctrl[`LIUHW_CTRL_RAIL] : rail_format_select;
		coder_bypass     = !single_rail;
		gauge_26         = host_mode ? ctrl[`LIUHW_CTRL_GAUGE] : cable_gauge_select;
		tx_term_internal = host_mode ? ctrl[`LIUHW_CTRL_TXT] : tx_termination_select;
		// Internal termination forces 1:2 and ignores the ratio input
		ratio_1_to_2     = tx_term_internal ? 1'b1
			: (host_mode ? ctrl[`LIUHW_CTRL_RATIO] : tx_transformer_ratio_select);
		term_impedance   = host_mode ? ctrl[`LIUHW_CTRL_TER_LO +: 2] : termination_impedance_select;
		// Impedance applies only when transmit and channel 0 receive both terminate internally
		term_impedance_valid = tx_term_internal && rx_term_internal[0];
		irq       = |(status & mask);
		int_n_out = 1'b0;
		int_n_oe  = host_mode && irq;
	end

	// Reset pin must stay low beyond the minimum before the device resets
	always_comb begin
		next_rst_cnt  = rst_cnt;
		next_in_reset = device_in_reset;
		if (chip_reset_n) begin
			next_rst_cnt  = 14'h0000;
			next_in_reset = 1'b0;
		end else if (rst_cnt <= 14'(RESET_CYCLES)) begin
			next_rst_cnt = rst_cnt + 14'h0001;
		end
		if (!chip_reset_n && rst_cnt >= 14'(RESET_CYCLES)) begin
			next_in_reset = 1'b1;
		end
	end

	assign take      = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_comb begin
		next_a_addr = take ? haddr : a_addr;
		next_a_wr   = take && hwrite;
		next_a_rd   = take && !hwrite;
		next_ctrl   = ctrl;
		next_loopreg = loopreg;
		next_mask   = mask;
		next_rxterm = rxterm;
		next_status = status;
		next_hrdata = hrdata;
		if (a_wr) begin
			if (a_addr == `LIUHW_OFF_CTRL) begin
				next_ctrl = hwdata;
			end else if (a_addr == `LIUHW_OFF_LOOP) begin
				next_loopreg = hwdata[2*NUM_CH-1:0];
			end else if (a_addr == `LIUHW_OFF_STATUS) begin
				next_status = status & ~hwdata[2*NUM_CH-1:0];
			end else if (a_addr == `LIUHW_OFF_MASK) begin
				next_mask = hwdata[2*NUM_CH-1:0];
			end else if (a_addr == `LIUHW_OFF_TERM) begin
				next_rxterm = hwdata[NUM_CH-1:0];
			end
		end
		// Rising edge of a fault or loss sets status; set beats clear
		next_status = next_status | (events & ~ev_prev);
		if (take && !hwrite) begin
			next_hrdata = 32'h0000_0000;
			if (haddr == `LIUHW_OFF_CTRL) begin
				next_hrdata = ctrl;
			end else if (haddr == `LIUHW_OFF_LOOP) begin
				next_hrdata = 32'(loopreg);
			end else if (haddr == `LIUHW_OFF_STATUS) begin
				next_hrdata = 32'(status);
			end else if (haddr == `LIUHW_OFF_MASK) begin
				next_hrdata = 32'(mask);
			end else if (haddr == `LIUHW_OFF_RAW) begin
				next_hrdata = 32'(events);
			end else if (haddr == `LIUHW_OFF_TERM) begin
				next_hrdata = 32'(rxterm);
			end else if (haddr == `LIUHW_OFF_CFG) begin
				next_hrdata = {22'h000000, device_in_reset, term_impedance, rx_term_internal[0],
					tx_term_internal, ratio_1_to_2, gauge_26, coder_bypass, single_rail, irq};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl            <= `LIUHW_RST_CTRL;
			loopreg         <= '0;
			mask            <= '0;
			status          <= '0;
			rxterm          <= '0;
			a_addr          <= 12'h000;
			a_wr            <= 1'b0;
			a_rd            <= 1'b0;
			hrdata          <= 32'h0000_0000;
			rst_cnt         <= 14'h0000;
			device_in_reset <= 1'b0;
			tclk_q          <= '0;
			ev_prev         <= '0;
		end else begin
			ctrl            <= next_ctrl;
			loopreg         <= next_loopreg;
			mask            <= next_mask;
			status          <= next_status;
			rxterm          <= next_rxterm;
			a_addr          <= next_a_addr;
			a_wr            <= next_a_wr;
			a_rd            <= next_a_rd;
			hrdata          <= next_hrdata;
			rst_cnt         <= next_rst_cnt;
			device_in_reset <= next_in_reset;
			tclk_q          <= channel_tx_clock;
			ev_prev         <= events;
		end
	end
endmodule

// ===== tb/liuhw_ctrl_assertions.sv
`timescale 1ns/1ps
module liuhw_ctrl_assertions #(
	parameter int NUM_CH       = 8,
	parameter int RESET_CYCLES = 1000
) (
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              chip_reset_n,
	input wire logic [NUM_CH-1:0] tx_data,
	input wire logic [NUM_CH-1:0] tx_line_data,
	input wire logic [NUM_CH-1:0] tx_send_all_ones,
	input wire logic              single_rail,
	input wire logic              coder_bypass,
	input wire logic [NUM_CH-1:0] lb_local,
	input wire logic [NUM_CH-1:0] lb_remote,
	input wire logic [NUM_CH-1:0] lb_digital,
	input wire logic              tx_term_internal,
	input wire logic              ratio_1_to_2,
	input wire logic              irq,
	input wire logic              int_n_out,
	input wire logic              int_n_oe,
	input wire logic [NUM_CH-1:0] tx_short_detect,
	input wire logic [NUM_CH-1:0] driver_fault_flag,
	input wire logic [NUM_CH-1:0] rx_analog_loss,
	input wire logic [NUM_CH-1:0] receive_loss_of_signal,
	input wire logic              device_in_reset
);
	int lowc;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Cycles the reset pin has been sampled low
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			lowc <= 0;
		else
			lowc <= chip_reset_n ? 0 : lowc + 1;

	line_data_a: assert property (tx_line_data == (tx_data | tx_send_all_ones))
		else $error("line data not forced to ones");
	rail_fmt_a: assert property (coder_bypass == !single_rail)
		else $error("coder bypass disagrees with rail format");
	loop_excl_a: assert property ($onehot0({lb_local[0], lb_remote[0], lb_digital[0]}))
		else $error("two loop modes at once");
	ratio_int_a: assert property (tx_term_internal |-> ratio_1_to_2)
		else $error("internal termination without fixed ratio");
	irq_pin_a: assert property (int_n_oe |-> irq && int_n_out == 1'b0)
		else $error("interrupt pin pulled without alarm");
	short_flag_a: assert property (tx_short_detect[0] [*3] |-> driver_fault_flag[0])
		else $error("short not flagged");
	loss_set_a: assert property ($rose(receive_loss_of_signal[0]) |-> $past(rx_analog_loss[0]))
		else $error("loss declared without analog loss");
	loss_clear_a: assert property (!rx_analog_loss[0] [*2] |-> !receive_loss_of_signal[0])
		else $error("loss held after analog loss gone");
	reset_hold_a: assert property (lowc > RESET_CYCLES + 2 |-> device_in_reset)
		else $error("long reset pulse ignored");
	reset_early_a: assert property ($rose(device_in_reset) |-> lowc >= RESET_CYCLES - 1)
		else $error("reset state entered too soon");
endmodule

bind liuhw_ctrl liuhw_ctrl_assertions #(.NUM_CH(NUM_CH), .RESET_CYCLES(RESET_CYCLES)) chk_i (.*);

// ===== tb/liuhw_line_model.sv
`timescale 1ns/1ps
module liuhw_line_model #(
	parameter int NUM_CH = 8,
	parameter int PWRUP  = 15
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              pulse_en,
	output logic      [NUM_CH-1:0] channel_tx_clock,
	output logic      [NUM_CH-1:0] tx_pulse_seen,
	output logic                   chip_reset_n
);
	int cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			channel_tx_clock <= '0;
		end else begin
			cnt <= (cnt < PWRUP) ? cnt + 1 : cnt;
			channel_tx_clock <= ~channel_tx_clock;
		end
	end

	// Power-up reset from the board
	assign chip_reset_n = (cnt >= PWRUP);
	// A dead driver shows no pulse on any clock
	assign tx_pulse_seen = pulse_en ? channel_tx_clock : '0;
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pulse_en = 1'b1;
	logic        auto_all_ones_on_loss = 1'b0, rail_format_select = 1'b0, cable_gauge_select = 1'b0;
	logic        tx_transformer_ratio_select = 1'b0, tx_termination_select = 1'b0, rx_termination_select = 1'b0;
	logic [1:0]  htrans = 2'h0, termination_impedance_select = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [11:0] haddr = 12'h000;
	logic [31:0] hwdata = 32'h0, rd;
	logic [7:0]  loopback_sel_hi = 8'h00, loopback_sel_lo = 8'h00, tx_short_detect = 8'h00, rx_bit_en = 8'h00;
	logic [7:0]  rx_bit = 8'h00, rx_analog_loss = 8'h00, tx_data = 8'h00;
	logic [15:0] seed = 16'h8D37;
	int          n_fail = 0, tests_run = 0;
	wire         hready, hreadyout, hresp, chip_reset_n, single_rail, coder_bypass, gauge_26, ratio_1_to_2;
	wire         tx_term_internal, term_impedance_valid, device_in_reset, irq, int_n_out, int_n_oe;
	wire [1:0]   term_impedance;
	wire [31:0]  hrdata;
	wire [7:0]   channel_tx_clock, tx_pulse_seen, driver_fault_flag, receive_loss_of_signal, tx_line_data;
	wire [7:0]   tx_send_all_ones, lb_local, lb_remote, lb_digital, rx_term_internal;

	assign hready = hreadyout;
	always #5 hclk = ~hclk;

	liuhw_line_model liuhw_line_model_i (.*);
	// Short reset count keeps the run brief
	liuhw_ctrl #(.RESET_CYCLES(10)) liuhw_ctrl_i (.*);

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	function automatic int zeros_for(input logic e1);
		return e1 ? 32 : 175;
	endfunction

	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic feed(input int n, input logic b);
		repeat (n) begin
			rx_bit_en <= 8'h01;
			rx_bit <= {7'h00, b};
			@(posedge hclk);
		end
		rx_bit_en <= 8'h00;
		repeat (3) @(posedge hclk);
	endtask

	task automatic loss_run(input logic e1);
		rx_analog_loss <= 8'h01;
		feed(20, 1'b0);
		feed(1, 1'b1);
		feed(zeros_for(e1) - 1, 1'b0);
		chk(receive_loss_of_signal[0] === 1'b0, "loss too early");
		feed(1, 1'b0);
		chk(receive_loss_of_signal[0] === 1'b1, "loss missing");
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		chk(device_in_reset === 1'b0, "reset state too soon");
		repeat (6) @(posedge hclk);
		chk(device_in_reset === 1'b1, "reset state missing");
		repeat (10) @(posedge hclk);
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			{auto_all_ones_on_loss, rail_format_select, cable_gauge_select, tx_transformer_ratio_select,
				tx_termination_select, rx_termination_select, termination_impedance_select} <= seed[7:0];
			loopback_sel_hi <= seed[15:8];
			seed = lfsr(seed);
			loopback_sel_lo <= seed[7:0];
			tx_data <= seed[15:8];
			@(posedge hclk);
			chk(coder_bypass === !rail_format_select, "coder bypass");
			chk(single_rail === rail_format_select, "rail format");
			chk(gauge_26 === cable_gauge_select, "gauge");
			chk(ratio_1_to_2 === (tx_termination_select | tx_transformer_ratio_select), "ratio");
			chk(lb_local === (~loopback_sel_hi & loopback_sel_lo), "local loop");
			chk(lb_remote === (loopback_sel_hi & ~loopback_sel_lo), "remote loop");
			chk(lb_digital === (loopback_sel_hi & loopback_sel_lo), "digital loop");
			chk(!tx_termination_select || term_impedance === termination_impedance_select, "ohm");
			chk(term_impedance_valid === (tx_termination_select & rx_termination_select), "ohm valid");
			chk(rx_term_internal === {8{rx_termination_select}}, "rx term pin");
			chk(tx_line_data === tx_data, "line data");
		end
		loss_run(1'b0);
		auto_all_ones_on_loss <= 1'b1;
		tx_data <= 8'h00;
		@(posedge hclk);
		chk(tx_line_data === 8'h01, "all ones missing");
		auto_all_ones_on_loss <= 1'b0;
		@(posedge hclk);
		chk(tx_send_all_ones === 8'h00, "all ones not off");
		rx_analog_loss <= 8'h00;
		repeat (3) @(posedge hclk);
		bus(1'b1, 12'h000, 32'h00000080, rd);
		loss_run(1'b1);
		rx_analog_loss <= 8'h00;
		pulse_en <= 1'b0;
		repeat (240) @(posedge hclk);
		chk(driver_fault_flag === 8'h00, "fault too early");
		repeat (40) @(posedge hclk);
		chk(driver_fault_flag === 8'hFF, "fault missing");
		pulse_en <= 1'b1;
		tx_short_detect <= seed[7:0];
		repeat (6) @(posedge hclk);
		chk(driver_fault_flag === seed[7:0], "short flag");
		tx_short_detect <= 8'h00;
		bus(1'b1, 12'h000, 32'h00000081, rd);
		bus(1'b1, 12'h00C, 32'h00000000, rd);
		@(posedge hclk);
		chk(irq === 1'b0 && int_n_oe === 1'b0, "masked irq");
		bus(1'b1, 12'h00C, 32'h00000001, rd);
		@(posedge hclk);
		chk(irq === 1'b1 && int_n_oe === 1'b1 && int_n_out === 1'b0, "irq pin");
		bus(1'b0, 12'h008, 32'h0, rd);
		chk(rd === 32'h000001FF, "status");
		bus(1'b1, 12'h008, 32'h0000FFFF, rd);
		@(posedge hclk);
		chk(irq === 1'b0 && int_n_oe === 1'b0, "irq not cleared");
		bus(1'b0, 12'h100, 32'h0, rd);
		chk(rd === 32'h00000000, "unmapped read");
		chk(hresp === 1'b0 && hreadyout === 1'b1, "bus response");
		bus(1'b1, 12'h014, 32'h00000055, rd);
		@(posedge hclk);
		chk(rx_term_internal === 8'h55, "rx term register");
		bus(1'b1, 12'h004, 32'h0000E4E4, rd);
		@(posedge hclk);
		chk(lb_local === 8'h22 && lb_remote === 8'h44 && lb_digital === 8'h88, "host loop");
		bus(1'b1, 12'h000, 32'h00000401, rd);
		@(posedge hclk);
		chk(rx_term_internal === {8{rx_termination_select}}, "rx term handed to pin");
		conclude();
	end
endmodule
